// ### core/aim_top.sv
// converter interrupt mask and channel result block with apb register port
`timescale 1ns/1ps
`default_nettype none
module aim_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_done,
  input wire logic [aim_pkg::CHW-1:0] conv_chan,
  input wire logic [aim_pkg::DW-1:0] conv_data,
  input wire logic rx_buffer_end_evt,
  input wire logic rx_buffer_full_evt,
  output logic irq
);
  aim_irq_if ib ();

  logic setup;
  logic access;
  logic wr_fire;
  logic is_res;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] reg_q_r;
  logic sel_res_r;
  logic [aim_pkg::DW-1:0] mem_q;
  logic [aim_pkg::NCH-1:0] chan_en_r;
  logic capture;
  logic [aim_pkg::NCH-1:0] conversion_done_n;
  logic [aim_pkg::NCH-1:0] channel_overrun_n;
  logic result_available;
  logic general_overrun;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr_fire = access & pwrite & pce;
  assign is_res = (paddr[7:5] == aim_pkg::OFS_RESULT[7:5]) && (paddr[1:0] == 2'h0);
  assign mapped = is_res || (paddr == aim_pkg::OFS_IRQ_EN) || (paddr == aim_pkg::OFS_IRQ_DIS)
    || (paddr == aim_pkg::OFS_IRQ_MASK) || (paddr == aim_pkg::OFS_STATUS)
    || (paddr == aim_pkg::OFS_CHAN_EN);

  // zero wait states; a frozen block stretches the access phase
  assign pready = pce;
  assign pslverr = access & ~mapped;

  // read value for non-result registers, write-only ones read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      aim_pkg::OFS_IRQ_MASK: rd_mux = {12'h000, ib.mask};
      aim_pkg::OFS_STATUS: rd_mux = {12'h000, ib.status};
      aim_pkg::OFS_CHAN_EN: rd_mux = {24'h00_0000, chan_en_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data sampled in the setup cycle, held through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reg_q_r <= 32'h0000_0000;
      sel_res_r <= 1'b0;
    end
    else if (pce && setup && !pwrite)
    begin
      reg_q_r <= rd_mux;
      sel_res_r <= is_res;
    end
  end

  assign prdata = sel_res_r ? {22'h00_0000, mem_q} : reg_q_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_en_r <= aim_pkg::CHAN_EN_RST;
    end
    else if (wr_fire && paddr == aim_pkg::OFS_CHAN_EN)
    begin
      chan_en_r <= pwdata[aim_pkg::NCH-1:0];
    end
  end

  // conversion of a disabled channel is dropped entirely
  assign capture = conv_done & chan_en_r[conv_chan];

  aim_res_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .ce(pce),
    .we(capture),
    .waddr(conv_chan),
    .wdata(conv_data),
    .re(setup & ~pwrite & is_res),
    .raddr(paddr[4:2]),
    .rdata_r(mem_q)
  );

  // per-channel done and overrun events
  for (genvar i = 0; i < aim_pkg::NCH; i++)
  begin : g_ch
    assign conversion_done_n[i] = capture && (conv_chan == aim_pkg::CHW'(i));
    assign channel_overrun_n[i] = conversion_done_n[i] && ib.status[aim_pkg::BIT_DONE + i];
  end

  assign result_available = capture;
  assign general_overrun = capture & ib.status[aim_pkg::BIT_RES_AVAIL];

  always_comb
  begin
    ib.events = '0;
    ib.events[aim_pkg::BIT_DONE +: aim_pkg::NCH] = conversion_done_n;
    ib.events[aim_pkg::BIT_CH_OVR +: aim_pkg::NCH] = channel_overrun_n;
    ib.events[aim_pkg::BIT_RES_AVAIL] = result_available;
    ib.events[aim_pkg::BIT_GEN_OVR] = general_overrun;
    ib.events[aim_pkg::BIT_RX_END] = rx_buffer_end_evt;
    ib.events[aim_pkg::BIT_RX_FULL] = rx_buffer_full_evt;
  end

  assign ib.ce = pce;
  assign ib.wdata = pwdata[aim_pkg::NSRC-1:0];
  assign ib.en_wr = wr_fire && (paddr == aim_pkg::OFS_IRQ_EN);
  assign ib.dis_wr = wr_fire && (paddr == aim_pkg::OFS_IRQ_DIS);
  assign ib.clr_wr = wr_fire && (paddr == aim_pkg::OFS_STATUS);

  aim_irq u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .bus(ib.ctl)
  );

  assign irq = ib.irq;
endmodule
`default_nettype wire

// ### core/aim_pkg.sv
// shared constants of the converter interrupt mask and channel result block
package aim_pkg;
  localparam int NCH = 8;
  localparam int DW = 10;
  localparam int NSRC = 20;
  localparam int CHW = 3;
  // byte offsets on the register bus
  localparam logic [7:0] OFS_IRQ_EN = 8'h00;
  localparam logic [7:0] OFS_IRQ_DIS = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_CHAN_EN = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h20;
  // event bit positions
  localparam int BIT_DONE = 0;
  localparam int BIT_CH_OVR = 8;
  localparam int BIT_RES_AVAIL = 16;
  localparam int BIT_GEN_OVR = 17;
  localparam int BIT_RX_END = 18;
  localparam int BIT_RX_FULL = 19;
  // reset values
  localparam logic [NSRC-1:0] MASK_RST = 20'h00000;
  localparam logic [NSRC-1:0] STATUS_RST = 20'h00000;
  localparam logic [NCH-1:0] CHAN_EN_RST = 8'h00;
  localparam logic [DW-1:0] RESULT_RST = 10'h000;
endpackage

// ### core/aim_irq_if.sv
// link between the register front end and the interrupt mask logic
`timescale 1ns/1ps
`default_nettype none
interface aim_irq_if;
  logic ce;
  logic en_wr;
  logic dis_wr;
  logic clr_wr;
  logic [aim_pkg::NSRC-1:0] wdata;
  logic [aim_pkg::NSRC-1:0] events;
  logic [aim_pkg::NSRC-1:0] mask;
  logic [aim_pkg::NSRC-1:0] status;
  logic irq;
  modport ctl (output ce, en_wr, dis_wr, clr_wr, wdata, events, input mask, status, irq);
  modport core (input ce, en_wr, dis_wr, clr_wr, wdata, events, output mask, status, irq);
endinterface
`default_nettype wire

// ### core/aim_res_mem.sv
// per-channel result store with registered read port
`timescale 1ns/1ps
`default_nettype none
module aim_res_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic we,
  input wire logic [aim_pkg::CHW-1:0] waddr,
  input wire logic [aim_pkg::DW-1:0] wdata,
  input wire logic re,
  input wire logic [aim_pkg::CHW-1:0] raddr,
  output logic [aim_pkg::DW-1:0] rdata_r
);
  logic [aim_pkg::DW-1:0] mem_r [aim_pkg::NCH];

  // a word changes only on a new capture, never on a read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < aim_pkg::NCH; i++)
      begin
        mem_r[i] <= aim_pkg::RESULT_RST;
      end
    end
    else if (ce && we)
    begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_r <= aim_pkg::RESULT_RST;
    end
    else if (ce && re)
    begin
      rdata_r <= mem_r[raddr];
    end
  end
endmodule
`default_nettype wire

// ### core/aim_irq.sv
// interrupt mask, sticky status and request output
`timescale 1ns/1ps
`default_nettype none
module aim_irq (
  input wire logic pclk,
  input wire logic presetn,
  aim_irq_if.core bus
);
  logic [aim_pkg::NSRC-1:0] mask_r;
  logic [aim_pkg::NSRC-1:0] mask_nxt;
  logic [aim_pkg::NSRC-1:0] status_r;
  logic [aim_pkg::NSRC-1:0] status_nxt;

  always_comb
  begin
    mask_nxt = mask_r;
    if (bus.en_wr)
    begin
      mask_nxt = mask_nxt | bus.wdata;
    end
    if (bus.dis_wr)
    begin
      mask_nxt = mask_nxt & ~bus.wdata;
    end
  end

  // new events win over a simultaneous clear
  always_comb
  begin
    status_nxt = status_r;
    if (bus.clr_wr)
    begin
      status_nxt = status_nxt & ~bus.wdata;
    end
    status_nxt = status_nxt | bus.events;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_r <= aim_pkg::MASK_RST;
    end
    else if (bus.ce)
    begin
      mask_r <= mask_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_r <= aim_pkg::STATUS_RST;
    end
    else if (bus.ce)
    begin
      status_r <= status_nxt;
    end
  end

  assign bus.mask = mask_r;
  assign bus.status = status_r;
  assign bus.irq = |(status_r & mask_r);
endmodule
`default_nettype wire

// ### sim/aim_top_asserts.sv
// port checker of the interrupt mask and result block
`timescale 1ns/1ps
`default_nettype none
module aim_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_done,
  input wire logic rx_buffer_end_evt,
  input wire logic rx_buffer_full_evt,
  input wire logic irq
);
  logic wr;
  logic cause;
  assign wr = psel && penable && pready && pwrite;
  assign cause = conv_done || rx_buffer_end_evt || rx_buffer_full_evt || wr;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  rdy_follow_a: assert property (pready == pce)
    else $error("pready wrong");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  err_map_a: assert property (psel && penable && paddr == aim_pkg::OFS_IRQ_DIS |-> !pslverr)
    else $error("disable address refused");
  irq_rise_a: assert property ($rose(irq) |-> $past(cause))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr))
    else $error("irq fell without write");
  irq_hold_a: assert property (irq && !wr |=> irq)
    else $error("irq dropped");
  dis_all_a: assert property (wr && paddr == aim_pkg::OFS_IRQ_DIS
    && pwdata[19:0] == 20'hfffff |=> !irq)
    else $error("irq after full disable");
  en_rx_a: assert property ((wr && paddr == aim_pkg::OFS_IRQ_EN && pwdata[18])
    ##2 (rx_buffer_end_evt && pce && !wr) |=> irq)
    else $error("rx end irq missing");
  cov_dis_c: cover property (wr && paddr == aim_pkg::OFS_IRQ_DIS);
  cov_irq_c: cover property ($rose(irq));
  cov_err_c: cover property (pslverr);
endmodule
bind aim_top aim_top_asserts aim_top_asserts_inst (.*);
`default_nettype wire

// ### sim/aim_top_test.sv
// self-checking testbench of the interrupt mask and result block
`timescale 1ns/1ps
`default_nettype none
module aim_top_test;
  logic pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, irq, err;
  logic conv_done, rx_buffer_end_evt, rx_buffer_full_evt;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, mask_m, stat_m;
  logic [2:0] conv_chan;
  logic [9:0] conv_data;
  logic [9:0] res_m [8];
  logic [7:0] chen_m;
  int n_errors = 0;
  int checks_done = 0;
  int unsigned seed = 52840;
  aim_top aim_top_inst (.*);
  initial
  begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      n_errors++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk(rd, exp);
  endtask
  // one event cycle; p low freezes the block
  task automatic ev(input logic d, e, f, p, input logic [2:0] c, input logic [9:0] x);
    @(posedge pclk);
    conv_done <= d;
    conv_chan <= c;
    conv_data <= x;
    rx_buffer_end_evt <= e;
    rx_buffer_full_evt <= f;
    pce <= p;
    if (p && d && chen_m[c])
    begin
      if (stat_m[c]) stat_m[8+c] = 1;
      if (stat_m[16]) stat_m[17] = 1;
      stat_m[c] = 1;
      stat_m[16] = 1;
      res_m[c] = x;
    end
    stat_m[18] |= e & p;
    stat_m[19] |= f & p;
    @(posedge pclk);
    conv_done <= 0;
    rx_buffer_end_evt <= 0;
    rx_buffer_full_evt <= 0;
    pce <= 1;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_errors++;
    close_out();
  end
  initial
  begin
    {psel, penable, pwrite, conv_done, rx_buffer_end_evt, rx_buffer_full_evt} = 6'h00;
    {paddr, pwdata, conv_chan, conv_data} = 53'h0;
    pce = 1;
    presetn = 0;
    {mask_m, stat_m, chen_m} = 72'h0;
    foreach (res_m[i]) res_m[i] = 10'h000;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rdchk(aim_pkg::OFS_IRQ_MASK, 32'h0);
    rdchk(aim_pkg::OFS_STATUS, 32'h0);
    for (int i = 0; i < 8; i++) rdchk(aim_pkg::OFS_RESULT + 8'(4 * i), 32'h0);
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      v = rnd();
      apb(1, aim_pkg::OFS_IRQ_EN, v);
      mask_m |= v & 32'h000fffff;
      rdchk(aim_pkg::OFS_IRQ_MASK, mask_m);
      v = rnd();
      apb(1, aim_pkg::OFS_IRQ_DIS, v);
      mask_m &= ~v & 32'h000fffff;
      rdchk(aim_pkg::OFS_IRQ_MASK, mask_m);
    end
    rdchk(aim_pkg::OFS_IRQ_DIS, 32'h0);
    rdchk(8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("mask test done");
    v = rnd();
    apb(1, aim_pkg::OFS_CHAN_EN, v);
    chen_m = v[7:0];
    apb(1, aim_pkg::OFS_IRQ_EN, 32'h00040000);
    mask_m[18] = 1;
    ev(0, 1, 0, 1, 3'h0, 10'h000);
    for (int i = 0; i < 24; i++)
    begin
      v = rnd();
      ev(v[0] | v[1], v[15] & v[16], v[17] & v[18], v[20:19] != 0, v[4:2], v[14:5]);
    end
    rdchk(aim_pkg::OFS_STATUS, stat_m);
    chk({31'h0, irq}, {31'h0, |(stat_m & mask_m)});
    for (int k = 0; k < 16; k++) rdchk(aim_pkg::OFS_RESULT + 8'(4 * (k % 8)), res_m[k % 8]);
    $display("conversion test done");
    apb(1, aim_pkg::OFS_STATUS, 32'h000fffff);
    rdchk(aim_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1, aim_pkg::OFS_IRQ_DIS, 32'h000fffff);
    rdchk(aim_pkg::OFS_IRQ_MASK, 32'h0);
    $display("clear test done");
    close_out();
  end
endmodule
`default_nettype wire
